// *** hw/cdp_pkg.sv ***
package cdp_pkg;

  // ----------------------------------------------------------------
  // bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cdp_wb_req_s;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CDP_OFF_CTRL = 8'h00;
  localparam logic [7:0] CDP_OFF_STATUS = 8'h04;
  localparam logic [7:0] CDP_OFF_SMASK = 8'h08;
  localparam logic [7:0] CDP_OFF_DPCFG = 8'h0C;
  localparam logic [7:0] CDP_OFF_CMASK = 8'h10;
  localparam logic [7:0] CDP_OFF_ORMASK = 8'h14;
  localparam logic [7:0] CDP_OFF_OSEL = 8'h18;
  localparam logic [7:0] CDP_OFF_FSTAT = 8'h1C;
  localparam logic [7:0] CDP_OFF_ACC0 = 8'h20;
  localparam logic [7:0] CDP_OFF_ACC1 = 8'h24;
  localparam logic [7:0] CDP_OFF_DREG0 = 8'h28;
  localparam logic [7:0] CDP_OFF_DREG1 = 8'h2C;
  localparam logic [7:0] CDP_OFF_FIFO0 = 8'h30;
  localparam logic [7:0] CDP_OFF_FIFO1 = 8'h34;
  localparam logic [2:0] CDP_CFGRAM_PAGE = 3'h2;

  // ----------------------------------------------------------------
  // datapath setup register fields and reset values
  // ----------------------------------------------------------------
  localparam int CDP_DP_MSB_LO = 0;
  localparam int CDP_DP_F0_OUT = 3;
  localparam int CDP_DP_F1_OUT = 4;
  localparam int CDP_DP_SI_LO = 5;
  localparam int CDP_DP_CMP0_SEL = 7;
  localparam int CDP_DP_CMP1_SEL = 8;
  localparam int CDP_DP_CHAIN_EN = 9;
  localparam int CDP_DP_EN = 10;
  localparam int CDP_DP_CLK_SEL = 11;
  localparam int CDP_SC_EN = 12;
  localparam int CDP_SC_CLK_SEL = 13;
  localparam logic [15:0] CDP_DPCFG_RST = 16'h1407;
  localparam logic [15:0] CDP_CMASK_RST = 16'hFFFF;
  localparam logic [23:0] CDP_OSEL_RST = 24'h00_0000;

  // ----------------------------------------------------------------
  // configuration word
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CDP_OP_INC, CDP_OP_DEC, CDP_OP_ADD, CDP_OP_SUB,
    CDP_OP_AND, CDP_OP_OR, CDP_OP_XOR, CDP_OP_PASS
  } cdp_op_e;
  typedef enum logic [1:0] {CDP_SH_NONE, CDP_SH_LEFT, CDP_SH_RIGHT, CDP_SH_SWAP} cdp_shift_e;
  typedef struct packed {
    cdp_op_e alu_op;
    logic [1:0] src_a;
    logic [1:0] src_b;
    cdp_shift_e shift;
    logic mask_en;
    logic [1:0] dest;
    logic fifo_wr;
    logic fifo_rd;
    logic crc_en;
    logic cin_sel;
  } cdp_cfg_s;

endpackage

// *** hw/cdp_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdp_alu #(
  parameter int W = 8,
  parameter int MW = 3
) (
  input wire logic [W-1:0] opa,
  input wire logic [W-1:0] opb,
  input wire cdp_pkg::cdp_op_e op,
  input wire cdp_pkg::cdp_shift_e shift,
  input wire logic cin,
  input wire logic si,
  input wire logic crc_en,
  input wire logic mask_en,
  input wire logic [MW-1:0] msb,
  input wire logic [W-1:0] or_mask,
  output logic [W-1:0] res,
  output logic cout,
  output logic sout,
  output logic ovf
);
  import cdp_pkg::*;

  logic [W:0] sum;
  logic [W-1:0] wm, am, bm, ar, sh;
  logic fb;

  // arithmetic, then shift/crc, then or-mask, all but the swap trimmed to the msb
  always_comb begin
    wm = {W{1'b1}} >> (MW'(W - 1) - msb);
    am = opa & wm;
    bm = '0;
    unique case (op)
      CDP_OP_INC: sum = {1'b0, am} + (W+1)'(1);
      CDP_OP_DEC: begin
        bm = wm;
        sum = {1'b0, am} + {1'b0, bm};
      end
      CDP_OP_ADD: begin
        bm = opb & wm;
        sum = {1'b0, am} + {1'b0, bm} + (W+1)'(cin);
      end
      CDP_OP_SUB: begin
        bm = ~opb & wm; // borrow in is the inverted carry
        sum = {1'b0, am} + {1'b0, bm} + (W+1)'(~cin);
      end
      CDP_OP_AND: sum = {1'b0, am & opb};
      CDP_OP_OR: sum = {1'b0, am | (opb & wm)};
      CDP_OP_XOR: sum = {1'b0, am ^ (opb & wm)};
      CDP_OP_PASS: sum = {1'b0, am};
    endcase
    ar = sum[W-1:0] & wm;
    cout = sum[int'(msb) + 1];
    ovf = (op inside {CDP_OP_INC, CDP_OP_DEC, CDP_OP_ADD, CDP_OP_SUB}) &
          (am[msb] ~^ bm[msb]) & (ar[msb] ^ am[msb]);
    fb = am[msb] ^ si;
    sh = ar;
    sout = 1'b0;
    if (crc_en) begin
      sh = ((am << 1) & wm) ^ (fb ? (opb & wm) : '0);
      sout = fb;
    end else begin
      unique case (shift)
        CDP_SH_NONE: sh = ar;
        CDP_SH_LEFT: begin
          sh = ((ar << 1) | W'(si)) & wm;
          sout = ar[msb];
        end
        CDP_SH_RIGHT: begin
          sh = (ar >> 1) | (W'(si) << msb);
          sout = ar[0];
        end
        CDP_SH_SWAP: sh = {ar[W/2-1:0], ar[W-1:W/2]};
      endcase
    end
    res = mask_en ? (sh | (or_mask & wm)) : sh;
  end

endmodule
`default_nettype wire

// *** hw/cdp_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] head,
  output logic empty,
  output logic full
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] lvl_q;
  logic do_push, do_pop;

  // a full push or an empty pop is dropped and leaves the contents alone
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign empty = (lvl_q == '0);
  assign full = (lvl_q == (PW+1)'(D));
  assign head = mem[rp_q];

  // storage has no reset, only the pointers need one
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == PW'(D - 1)) ? '0 : wp_q + PW'(1);
      end
      if (do_pop) begin
        rp_q <= (rp_q == PW'(D - 1)) ? '0 : rp_q + PW'(1);
      end
      lvl_q <= lvl_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  AST_FIFO_FULL_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (full && push && !pop) |=> (full && $stable(lvl_q)))
    else $error("push into full fifo changed it");
  AST_FIFO_EMPTY_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (empty && pop && !push) |=> empty)
    else $error("pop from empty fifo changed it");

endmodule
`default_nettype wire

// *** hw/cdp_top.sv ***
// What this block does
// - eight sixteen-bit configuration words held on chip
// - routing picks the active configuration every cycle
// - alu does inc dec add sub and or xor pass
// - pass forwards operand, trimmed to the msb, to later stages
// - shift left/right, swap, or-mask chosen independently
// - two masked compares over accumulators and data registers
// - zero, ones, overflow; selected conditions drive outputs
// - compare equality chains through a dedicated neighbour link
// - programmable msb for arithmetic and shifting
// - one crc or pseudo random step each cycle
// - two four-byte fifos, direction set per fifo
// - input: bus writes, datapath reads; output reversed
// - fifo flags selectable as routing outputs
// - carry, shift and conditions exchanged with neighbours
// - carry and shift out registered for later reuse
// - six routing inputs and six routing outputs
// - bus-written control bits drive routing signals
// - read-only status shows internal routing signals
// - status bit may latch until read clears it
// - datapath and control/status each enabled and clocked separately
// - accumulators are alu sources, sinks and compare sources
// - data registers are sources only, never alu sinks
// - eight-bit alu finishes in one cycle
`timescale 1ns/1ps
`default_nettype none
module cdp_top #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int NCFG = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire cdp_pkg::cdp_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] route_in,
  output logic [5:0] route_out,
  input wire logic [7:0] status_in,
  output logic [7:0] ctrl_route,
  input wire logic chain_carry_in,
  input wire logic chain_shift_in,
  input wire logic chain_eq_in,
  output logic chain_carry_out,
  output logic chain_shift_out,
  output logic chain_eq_out
);
  import cdp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, stat_q, smask_q, ormask_q;
  logic [15:0] dpcfg_q, cmask_q;
  logic [23:0] osel_q;
  logic [W-1:0] acc0_q, acc1_q, dreg0_q, dreg1_q;
  logic [15:0] cfg_ram [NCFG];
  logic carry_q, shift_q, ack_q, eq_q;
  logic [31:0] rdat_q;
  logic [5:0] rout_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic acc, wr_acc, rd_acc;
  logic [7:0] adr;
  assign acc = wb_req.cyc & wb_req.stb & ~ack_q;
  assign wr_acc = acc & wb_req.we;
  assign rd_acc = acc & ~wb_req.we;
  assign adr = wb_req.adr;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // byte lanes not selected keep their old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old);
    for (int i = 0; i < 4; i++) begin
      lane_merge[8*i +: 8] = wb_req.sel[i] ? wb_req.dat[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic hit(input logic [7:0] off);
    return wr_acc && (adr == off);
  endfunction

  // ----------------------------------------------------------------
  // sub-block enables and their selectable clock
  // ----------------------------------------------------------------
  // a sub-block may run every cycle or only on a routed tick, so the
  // datapath and the control/status pair can be assigned separately
  logic dp_tick, sc_tick;
  assign dp_tick = dpcfg_q[CDP_DP_EN] & (~dpcfg_q[CDP_DP_CLK_SEL] | route_in[4]);
  assign sc_tick = dpcfg_q[CDP_SC_EN] & (~dpcfg_q[CDP_SC_CLK_SEL] | route_in[5]);

  // ----------------------------------------------------------------
  // configuration fetch and operand selection
  // ----------------------------------------------------------------
  cdp_cfg_s cfg;
  logic [W-1:0] opa, opb, alu_res;
  logic alu_cout, alu_sout, alu_ovf, cin, si;
  logic [2:0] msb;

  // the routed address is read fresh in every cycle
  assign cfg = cdp_cfg_s'(cfg_ram[route_in[2:0]]);
  assign msb = dpcfg_q[CDP_DP_MSB_LO +: 3];

  // both accumulators and both data registers can feed either port
  function automatic logic [W-1:0] opsel(input logic [1:0] s);
    unique case (s)
      2'd0: return acc0_q;
      2'd1: return acc1_q;
      2'd2: return dreg0_q;
      2'd3: return dreg1_q;
    endcase
  endfunction
  assign opa = opsel(cfg.src_a);
  assign opb = opsel(cfg.src_b);

  // registered carry lets one slice run a wide word over two cycles
  assign cin = cfg.cin_sel ? carry_q : (dpcfg_q[CDP_DP_CHAIN_EN] & chain_carry_in);

  // shift source: routed serial in, neighbour, own registered bit
  always_comb begin
    unique case (dpcfg_q[CDP_DP_SI_LO +: 2])
      2'd0: si = route_in[3];
      2'd1: si = chain_shift_in;
      2'd2: si = shift_q;
      2'd3: si = 1'b0;
    endcase
  end

  cdp_alu #(.W(W), .MW(3)) u_alu (
    .opa(opa),
    .opb(opb),
    .op(cfg.alu_op),
    .shift(cfg.shift),
    .cin(cin),
    .si(si),
    .crc_en(cfg.crc_en),
    .mask_en(cfg.mask_en),
    .msb(msb),
    .or_mask(ormask_q),
    .res(alu_res),
    .cout(alu_cout),
    .sout(alu_sout),
    .ovf(alu_ovf)
  );

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  logic [1:0] f_out, f_push, f_pop, f_empty, f_full;
  logic [W-1:0] f_head [2];
  logic [W-1:0] f_wdat [2];
  assign f_out = {dpcfg_q[CDP_DP_F1_OUT], dpcfg_q[CDP_DP_F0_OUT]};

  // input side: bus fills, datapath drains; output side the reverse
  for (genvar g = 0; g < 2; g++) begin : g_fifo
    logic [7:0] off;
    assign off = g ? CDP_OFF_FIFO1 : CDP_OFF_FIFO0;
    assign f_push[g] = f_out[g] ? (dp_tick & cfg.fifo_wr) : hit(off);
    assign f_pop[g] = f_out[g] ? (rd_acc & (adr == off)) : (dp_tick & cfg.fifo_rd);
    assign f_wdat[g] = f_out[g] ? alu_res : wb_req.dat[W-1:0];
    cdp_fifo #(.W(W), .D(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .push(f_push[g]),
      .pop(f_pop[g]),
      .wdata(f_wdat[g]),
      .head(f_head[g]),
      .empty(f_empty[g]),
      .full(f_full[g])
    );
  end

  // ----------------------------------------------------------------
  // conditions
  // ----------------------------------------------------------------
  logic [W-1:0] c0b, c1b, m0, m1;
  logic ce0, cl0, ce1, cl1, ceq;
  logic [15:0] cond;
  assign m0 = cmask_q[7:0];
  assign m1 = cmask_q[15:8];
  assign c0b = dpcfg_q[CDP_DP_CMP0_SEL] ? acc1_q : dreg0_q;
  assign c1b = dpcfg_q[CDP_DP_CMP1_SEL] ? acc0_q : dreg1_q;
  assign ce0 = (acc0_q & m0) == (c0b & m0);
  assign cl0 = (acc0_q & m0) < (c0b & m0);
  assign ce1 = (acc1_q & m1) == (c1b & m1);
  assign cl1 = (acc1_q & m1) < (c1b & m1);
  // equality of a wider word is this slice and every lower slice
  assign ceq = ce0 & (~dpcfg_q[CDP_DP_CHAIN_EN] | chain_eq_in);

  // index of each condition as seen by the output selects
  assign cond = {
    f_full[1], f_empty[1], f_full[0], f_empty[0],
    ceq, shift_q, carry_q, alu_ovf,
    &acc1_q, &acc0_q, ~|acc1_q, ~|acc0_q,
    cl1, ce1, cl0, ce0
  };

  // ----------------------------------------------------------------
  // routing outputs and chain outputs
  // ----------------------------------------------------------------
  // every routed output is a flop so it meets timing anywhere it goes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rout_q <= '0;
      eq_q <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        rout_q[i] <= cond[osel_q[4*i +: 4]];
      end
      eq_q <= ceq;
    end
  end
  assign route_out = rout_q;
  assign chain_eq_out = eq_q;
  assign chain_carry_out = carry_q;
  assign chain_shift_out = shift_q;
  assign ctrl_route = ctrl_q;

  // ----------------------------------------------------------------
  // datapath registers
  // ----------------------------------------------------------------
  // bus writes win over a same-cycle datapath write to the same register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc0_q <= '0;
      acc1_q <= '0;
      carry_q <= 1'b0;
      shift_q <= 1'b0;
    end else begin
      if (dp_tick) begin
        carry_q <= alu_cout;
        shift_q <= alu_sout;
      end
      if (hit(CDP_OFF_ACC0)) begin
        acc0_q <= W'(lane_merge(32'(acc0_q)));
      end else if (dp_tick && cfg.dest[0]) begin
        acc0_q <= alu_res;
      end
      if (hit(CDP_OFF_ACC1)) begin
        acc1_q <= W'(lane_merge(32'(acc1_q)));
      end else if (dp_tick && cfg.dest[1]) begin
        acc1_q <= alu_res;
      end
    end
  end

  // data registers load from bus or their own input fifo, never the alu
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dreg0_q <= '0;
      dreg1_q <= '0;
    end else begin
      if (hit(CDP_OFF_DREG0)) begin
        dreg0_q <= W'(lane_merge(32'(dreg0_q)));
      end else if (f_pop[0] && !f_out[0] && !f_empty[0]) begin
        dreg0_q <= f_head[0];
      end
      if (hit(CDP_OFF_DREG1)) begin
        dreg1_q <= W'(lane_merge(32'(dreg1_q)));
      end else if (f_pop[1] && !f_out[1] && !f_empty[1]) begin
        dreg1_q <= f_head[1];
      end
    end
  end

  // configuration store, written only from the bus; cleared at reset so a
  // datapath that is enabled out of reset never computes from unknown words
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg_ram[i] <= '0;
      end
    end else if (wr_acc && adr[7:5] == CDP_CFGRAM_PAGE) begin
      cfg_ram[adr[4:2]] <= 16'(lane_merge(32'(cfg_ram[adr[4:2]])));
    end
  end

  // ----------------------------------------------------------------
  // setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= '0;
      smask_q <= '0;
      dpcfg_q <= CDP_DPCFG_RST;
      cmask_q <= CDP_CMASK_RST;
      ormask_q <= '0;
      osel_q <= CDP_OSEL_RST;
    end else begin
      if (hit(CDP_OFF_CTRL)) ctrl_q <= 8'(lane_merge(32'(ctrl_q)));
      if (hit(CDP_OFF_SMASK)) smask_q <= 8'(lane_merge(32'(smask_q)));
      if (hit(CDP_OFF_DPCFG)) dpcfg_q <= 16'(lane_merge(32'(dpcfg_q)));
      if (hit(CDP_OFF_CMASK)) cmask_q <= 16'(lane_merge(32'(cmask_q)));
      if (hit(CDP_OFF_ORMASK)) ormask_q <= 8'(lane_merge(32'(ormask_q)));
      if (hit(CDP_OFF_OSEL)) osel_q <= 24'(lane_merge(32'(osel_q)));
    end
  end

  // ----------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------
  // masked bits latch until read; a new event in the read cycle survives
  logic stat_clr;
  assign stat_clr = rd_acc && (adr == CDP_OFF_STATUS);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= '0;
    end else if (sc_tick) begin
      for (int i = 0; i < 8; i++) begin
        if (smask_q[i]) begin
          stat_q[i] <= (stat_q[i] & ~stat_clr) | status_in[i];
        end else begin
          stat_q[i] <= status_in[i];
        end
      end
    end else if (stat_clr) begin
      stat_q <= stat_q & ~smask_q;
    end
  end

  // ----------------------------------------------------------------
  // bus answer: one cycle after the request, unmapped reads return zero
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = '0;
    if (adr[7:5] == CDP_CFGRAM_PAGE) begin
      rmux = 32'(cfg_ram[adr[4:2]]);
    end else begin
      case (adr)
        CDP_OFF_CTRL: rmux = 32'(ctrl_q);
        CDP_OFF_STATUS: rmux = 32'(stat_q);
        CDP_OFF_SMASK: rmux = 32'(smask_q);
        CDP_OFF_DPCFG: rmux = 32'(dpcfg_q);
        CDP_OFF_CMASK: rmux = 32'(cmask_q);
        CDP_OFF_ORMASK: rmux = 32'(ormask_q);
        CDP_OFF_OSEL: rmux = 32'(osel_q);
        CDP_OFF_FSTAT: rmux = 32'({f_full, f_empty});
        CDP_OFF_ACC0: rmux = 32'(acc0_q);
        CDP_OFF_ACC1: rmux = 32'(acc1_q);
        CDP_OFF_DREG0: rmux = 32'(dreg0_q);
        CDP_OFF_DREG1: rmux = 32'(dreg1_q);
        CDP_OFF_FIFO0: rmux = 32'(f_head[0]);
        CDP_OFF_FIFO1: rmux = 32'(f_head[1]);
        default: rmux = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= acc;
      if (rd_acc) rdat_q <= rmux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_BUS_ACK: assert property (s_req |=> s_answer)
    else $error("bus answer not a single cycle after request");
  AST_CTRL_DRIVE: assert property (
    (s_req and (wb_req.we && adr == CDP_OFF_CTRL && wb_req.sel[0]))
    |=> ctrl_route == $past(wb_req.dat[7:0]))
    else $error("control write did not reach routing");
  AST_STAT_LATCH: assert property (
    (sc_tick && smask_q[0] && status_in[0]) |=> stat_q[0])
    else $error("latched status bit lost its event");
  AST_STAT_CLEAR: assert property (
    (stat_clr && sc_tick && smask_q[0] && !status_in[0]) |=> !stat_q[0])
    else $error("status read did not clear latched bit");
  AST_CARRY_KEEP: assert property (dp_tick |=> carry_q == $past(alu_cout))
    else $error("registered carry differs from alu carry");
  AST_ACC_DEST: assert property (
    (dp_tick && cfg.dest[0] && !hit(CDP_OFF_ACC0)) |=> acc0_q == $past(alu_res))
    else $error("accumulator did not take alu result");
  AST_PASS_THROUGH: assert property (
    (dp_tick && cfg.alu_op == CDP_OP_PASS && cfg.shift == CDP_SH_NONE && !cfg.crc_en
     && !cfg.mask_en && msb == 3'd7 && cfg.dest == 2'b01 && !hit(CDP_OFF_ACC0))
    |=> acc0_q == $past(opa))
    else $error("pass did not forward the operand");

endmodule
`default_nettype wire

// *** test/cdp_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// routing-side sequencer: picks a config word and raises the datapath tick
module cdp_seq_model (
  input wire logic ref_clk,
  output logic [5:0] route_in,
  output logic [7:0] status_in
);
  initial begin
    route_in = 6'h00;
    status_in = 8'h00;
  end
  // one tick on entry idx, then idle so the slice holds its state
  task automatic step(input logic [2:0] idx);
    @(posedge ref_clk);
    route_in <= {3'b010, idx};
    @(posedge ref_clk);
    route_in <= 6'h00;
  endtask
  // single-cycle event: only a latching status bit can keep it
  task automatic pulse(input logic [7:0] b);
    @(posedge ref_clk);
    status_in <= b;
    @(posedge ref_clk);
    status_in <= 8'h00;
  endtask
endmodule
`default_nettype wire

// *** test/tb_cdp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cdp_top;
  import cdp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  cdp_wb_req_s wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] route_in;
  logic [5:0] route_out;
  logic [7:0] status_in;
  logic [7:0] ctrl_route;
  logic [2:0] chain_in = 3'b000;
  logic [2:0] chain_out;
  int err_total = 0;
  int cmp_count = 0;
  // pass dreg0, add, xor+shl, inc+swap, pass+ormask, crc step, fifo pop
  logic [15:0] cfg [7] = '{16'hF010, 16'h4410, 16'hC4A0, 16'h0190, 16'hF060, 16'hE422,
    16'h0004};

  always #50 ref_clk = ~ref_clk;

  // the bench plays the neighbour slice on the chain link
  cdp_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .route_in(route_in),
    .route_out(route_out), .status_in(status_in), .ctrl_route(ctrl_route),
    .chain_carry_in(chain_in[0]), .chain_shift_in(chain_in[1]),
    .chain_eq_in(chain_in[2]), .chain_carry_out(chain_out[0]),
    .chain_shift_out(chain_out[1]), .chain_eq_out(chain_out[2]));
  cdp_seq_model pm_u (.ref_clk(ref_clk), .route_in(route_in), .status_in(status_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // classic cycle; ack and data are taken at the edge where ack is high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:a, dat:d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) begin
      err_total++;
      conclude();
    end
    wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(v, e);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({18'h0_0000, route_out, ctrl_route}, 32'h0000_0000);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(CDP_OFF_DPCFG, {16'h0000, CDP_DPCFG_RST});
    rdc(CDP_OFF_CMASK, {16'h0000, CDP_CMASK_RST});
    rdc(CDP_OFF_FSTAT, 32'h0000_0003);
    rdc(8'h3C, 32'h0000_0000);
    wr(CDP_OFF_CTRL, 32'h0000_00A5);
    chk({24'h00_0000, ctrl_route}, 32'h0000_00A5);
    // tick-gated datapath so the unloaded ram cannot disturb the accumulators
    wr(CDP_OFF_DPCFG, 32'h0000_1C07);
    wr(CDP_OFF_DREG0, 32'h0000_003C);
    wr(CDP_OFF_ORMASK, 32'h0000_0003);
    wr(CDP_OFF_SMASK, 32'h0000_0001);
    foreach (cfg[i]) wr({CDP_CFGRAM_PAGE, 3'(i), 2'b00}, {16'h0000, cfg[i]});
    pm_u.step(3'd0);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({23'h00_0000, chain_out, route_out}, 32'h0000_013F);
    pm_u.step(3'd1);
    pm_u.step(3'd2);
    rdc(CDP_OFF_ACC1, 32'h0000_0088);
    pm_u.step(3'd3);
    rdc(CDP_OFF_ACC0, 32'h0000_0097);
    pm_u.step(3'd4);
    rdc(CDP_OFF_ACC1, 32'h0000_003F);
    rdc(CDP_OFF_DREG0, 32'h0000_003C);
    pm_u.step(3'd5);
    rdc(CDP_OFF_ACC1, 32'h0000_0012);
    // route output 0 shows fifo 0 full; the fifth push must be dropped
    wr(CDP_OFF_OSEL, 32'h0000_000D);
    for (int k = 1; k < 6; k++) wr(CDP_OFF_FIFO0, 32'h0000_0011 * 32'(k));
    rdc(CDP_OFF_FSTAT, 32'h0000_0006);
    chk(32'(route_out[0]), 32'h0000_0001);
    rdc(CDP_OFF_FIFO0, 32'h0000_0011);
    // four pops drain it, the fifth finds it empty and changes nothing
    repeat (5) pm_u.step(3'd6);
    rdc(CDP_OFF_DREG0, 32'h0000_0044);
    rdc(CDP_OFF_FSTAT, 32'h0000_0003);
    pm_u.pulse(8'h01);
    repeat (2) @(posedge ref_clk);
    rdc(CDP_OFF_STATUS, 32'h0000_0001);
    rdc(CDP_OFF_STATUS, 32'h0000_0000);
    // open masks make the local compare true, so the neighbour decides
    wr(CDP_OFF_CMASK, 32'h0000_0000);
    wr(CDP_OFF_DPCFG, 32'h0000_1E07);
    @(negedge ref_clk);
    chk(32'(chain_out), 32'h0000_0000);
    @(posedge ref_clk);
    chain_in <= 3'b100;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(32'(chain_out), 32'h0000_0004);
    conclude();
  end
endmodule
`default_nettype wire
